// ===== include/pdt_pkg.sv
// constants for the prescaled down-counter timer
package pdt_pkg;
   localparam logic [7:0] ADDR_PRESCALE = 8'hD2;
   localparam logic [7:0] ADDR_COUNT = 8'hD3;
   localparam logic [7:0] ADDR_CONTROL = 8'hD4;
   localparam logic [7:0] COUNT_RESET = 8'hFF;
   localparam logic [6:0] PRESCALE_RESET = 7'h7F;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] COUNT_ZERO = 8'h00;
   localparam int BIT_ZERO_FLAG = 7;
   localparam int BIT_IRQ_EN = 6;
   localparam int BIT_PIN_DIR = 5;
   localparam int BIT_DATA_OUT = 4;
   localparam int BIT_RUN = 3;
   localparam int FIELD_TAP_HI = 2;
   localparam int INT_DIV = 12;
   localparam logic [3:0] INT_DIV_LAST = 4'(INT_DIV - 1);
   localparam logic [7:0] TIMER_VECTOR = 8'h03;
endpackage : pdt_pkg

// ===== include/pdt_tick_if.sv
// tick and configuration signals between the timer core and its clock source
`timescale 1ns/1ns
interface pdt_tick_if;
   logic run;
   logic pin_in;
   logic pin_dir;
   logic data_out;
   logic tick;
   modport src (input run, input pin_in, input pin_dir, input data_out,
      output tick);
   modport core (output run, output pin_in, output pin_dir,
      output data_out, input tick);
endinterface : pdt_tick_if

// ===== hw/pdt_tick_src.sv
// prescaler input clock source: internal divide by 12, gated, or pin edges
`timescale 1ns/1ns
module pdt_tick_src (
   input wire logic mclk_i,
   input wire logic rst_i,
   pdt_tick_if.src tif
);
   logic [3:0] div_reg;
   logic pin_reg;
   wire div_wrap = (div_reg == pdt_pkg::INT_DIV_LAST);
   wire pin_rise = tif.pin_in & ~pin_reg;
   wire gated_ok = ~tif.pin_dir & tif.data_out ? tif.pin_in : 1'b1;
   wire event_mode = ~tif.pin_dir & ~tif.data_out;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         div_reg <= 4'h0;
         pin_reg <= 1'b0;
      end else begin
         div_reg <= (div_wrap | ~tif.run) ? 4'h0 : div_reg + 4'h1;
         pin_reg <= tif.pin_in;
      end
   end
   // pin is synchronous per clocking assumption; edge taken straight off it
   assign tif.tick = tif.run & (event_mode ? pin_rise
      : (div_wrap & gated_ok));
endmodule : pdt_tick_src

// ===== hw/pdt_timer.sv
// 8-bit down-counter timer with 7-bit prescaler and data-space registers
`timescale 1ns/1ns
module pdt_timer (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic timer_pin_i,
   output logic [7:0] rdata_o,
   output logic timer_pin_o,
   output logic timer_pin_oe_o,
   output logic irq_o,
   output logic [7:0] irq_vector_o
);
   logic [7:0] count_value_reg;
   logic [6:0] prescale_state_reg;
   logic [7:0] timer_control_status_reg;
   logic [7:0] rdata_reg;
   logic pin_latch_reg;
   logic irq_reg;
   logic [7:0] vector_reg;
   logic [6:0] prescale_next;
   logic [7:0] count_next;
   logic [7:0] control_next;
   pdt_tick_if tif ();

   pdt_tick_src u_src (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .tif(tif)
   );

   wire zero_flag = timer_control_status_reg[pdt_pkg::BIT_ZERO_FLAG];
   wire zero_irq_enable = timer_control_status_reg[pdt_pkg::BIT_IRQ_EN];
   wire pin_direction_sel = timer_control_status_reg[pdt_pkg::BIT_PIN_DIR];
   wire data_out = timer_control_status_reg[pdt_pkg::BIT_DATA_OUT];
   wire prescaler_run = timer_control_status_reg[pdt_pkg::BIT_RUN];
   wire [2:0] tap_sel = timer_control_status_reg[pdt_pkg::FIELD_TAP_HI:0];

   assign tif.run = prescaler_run;
   assign tif.pin_in = timer_pin_i;
   assign tif.pin_dir = pin_direction_sel;
   assign tif.data_out = data_out;

   wire wr_psc = wr_i & (addr_i == pdt_pkg::ADDR_PRESCALE);
   wire wr_cnt = wr_i & (addr_i == pdt_pkg::ADDR_COUNT);
   wire wr_ctl = wr_i & (addr_i == pdt_pkg::ADDR_CONTROL);

   // tap bit n-1 rises 0->1 when the low n bits are all zero on a tick
   function automatic logic tap_fire(input logic [6:0] ps,
      input logic [2:0] sel);
      logic [7:0] low;
      low = 8'((8'h01 << sel) - 8'h01);
      tap_fire = (sel == 3'h0) ? 1'b1 : (({1'b0, ps} & low) == 8'h00);
   endfunction : tap_fire

   wire prescale_tick = tif.tick & prescaler_run;
   wire count_tick = prescale_tick
      & tap_fire(prescale_state_reg, tap_sel);
   wire dec_to_zero = count_tick & (count_value_reg == 8'h01);

   always_comb begin
      if (!prescaler_run)
         prescale_next = pdt_pkg::PRESCALE_RESET;
      else if (wr_psc)
         prescale_next = wdata_i[6:0];
      else if (prescale_tick)
         prescale_next = prescale_state_reg - 7'h01;
      else
         prescale_next = prescale_state_reg;
   end

   always_comb begin
      if (wr_cnt)
         count_next = wdata_i;
      else if (count_tick)
         count_next = count_value_reg - 8'h01;
      else
         count_next = count_value_reg;
   end

   always_comb begin
      control_next = wr_ctl ? wdata_i : timer_control_status_reg;
      // set wins over a software clear in the same cycle
      if ((dec_to_zero & ~wr_cnt)
            | (wr_cnt & (wdata_i == pdt_pkg::COUNT_ZERO)))
         control_next[pdt_pkg::BIT_ZERO_FLAG] = 1'b1;
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         count_value_reg <= pdt_pkg::COUNT_RESET;
         prescale_state_reg <= pdt_pkg::PRESCALE_RESET;
         timer_control_status_reg <= pdt_pkg::CONTROL_RESET;
      end else begin
         count_value_reg <= count_next;
         prescale_state_reg <= prescale_next;
         timer_control_status_reg <= control_next;
      end
   end

   // read mux on live registers; top prescale bit always zero
   wire [7:0] rd_mux =
      (addr_i == pdt_pkg::ADDR_PRESCALE) ? {1'b0, prescale_state_reg} :
      (addr_i == pdt_pkg::ADDR_COUNT) ? count_value_reg :
      (addr_i == pdt_pkg::ADDR_CONTROL) ? timer_control_status_reg :
      8'h00;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= 8'h00;
         pin_latch_reg <= 1'b0;
         irq_reg <= 1'b0;
         vector_reg <= pdt_pkg::TIMER_VECTOR;
      end else begin
         vector_reg <= pdt_pkg::TIMER_VECTOR;
         rdata_reg <= rd_i ? rd_mux : 8'h00;
         if (zero_flag)
            pin_latch_reg <= data_out;
         irq_reg <= zero_flag & zero_irq_enable;
      end
   end

   // pin enable is registered so the output stays glitch free
   logic oe_reg;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i)
         oe_reg <= 1'b0;
      else
         oe_reg <= control_next[pdt_pkg::BIT_PIN_DIR];
   end

   assign rdata_o = rdata_reg;
   assign timer_pin_o = pin_latch_reg;
   assign timer_pin_oe_o = oe_reg;
   assign irq_o = irq_reg;
   assign irq_vector_o = vector_reg;

   // flag low on two edges running means the pin latch is closed
   sequence seq_flag_low_twice;
      !zero_flag ##1 !zero_flag;
   endsequence
   sequence seq_clean_dec;
      dec_to_zero && !wr_cnt;
   endsequence

   AST_WRITE_ZERO_SETS: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      wr_cnt && wdata_i == pdt_pkg::COUNT_ZERO |=> zero_flag)
      else $error("zero flag not set by writing zero");
   AST_FLAG_WRITE_SETS: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      wr_ctl && wdata_i[pdt_pkg::BIT_ZERO_FLAG] |=> zero_flag)
      else $error("zero flag not set by control write");
   AST_DEC_SETS: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      seq_clean_dec |=> zero_flag)
      else $error("zero flag not set by count reaching zero");
   AST_ZERO_STAYS: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      zero_flag && !wr_ctl |=> zero_flag)
      else $error("zero flag cleared without software");
   AST_WRITE_WINS: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      wr_cnt && count_tick |=> count_value_reg == $past(wdata_i))
      else $error("counter write lost to decrement");
   AST_WIN_NO_FLAG: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      wr_cnt && dec_to_zero && wdata_i != pdt_pkg::COUNT_ZERO
      |=> zero_flag == $past(zero_flag))
      else $error("zero flag set although write won");
   AST_IRQ_GATE: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      ##1 irq_o == $past(zero_flag & zero_irq_enable))
      else $error("interrupt not tied to flag and enable");
   AST_IRQ_OFF: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !zero_irq_enable |=> !irq_o)
      else $error("interrupt raised while disabled");
   AST_STOPPED: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !prescaler_run && !wr_cnt |=> $stable(count_value_reg)
      && prescale_state_reg == pdt_pkg::PRESCALE_RESET)
      else $error("timer moved while stopped");
   AST_NO_TICK_STOPPED: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !prescaler_run |-> !count_tick)
      else $error("counter clocked while stopped");
   AST_PSC_DEC: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      prescale_tick && !wr_psc |=>
      prescale_state_reg == $past(prescale_state_reg) - 7'h01)
      else $error("prescaler did not step down");
   AST_COUNT_DIV1: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      prescale_tick && tap_sel == 3'h0 && !wr_cnt |=>
      count_value_reg == $past(count_value_reg) - 8'h01)
      else $error("counter missed a prescaler input tick");
   AST_WRAP: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      count_tick && !wr_cnt && count_value_reg == pdt_pkg::COUNT_ZERO
      |=> count_value_reg == '1)
      else $error("counter did not wrap");
   AST_PIN_HOLD: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      seq_flag_low_twice |-> $stable(timer_pin_o))
      else $error("pin changed with flag low");
   AST_PIN_FOLLOW: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      zero_flag |=> timer_pin_o == $past(data_out))
      else $error("pin latch not transparent with flag high");
   AST_OE_DIR: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      timer_pin_oe_o == pin_direction_sel)
      else $error("pin enable differs from direction bit");
   AST_READ_LIVE: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      rd_i && addr_i == pdt_pkg::ADDR_COUNT |=>
      rdata_o == $past(count_value_reg))
      else $error("counter read not live");
   AST_READ_IDLE: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !rd_i |=> rdata_o == '0)
      else $error("read data not cleared without a read");
   AST_PSC_TOP: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      rd_i && addr_i == pdt_pkg::ADDR_PRESCALE |=> !rdata_o[$high(rdata_o)])
      else $error("prescaler top bit read nonzero");
endmodule : pdt_timer

// ===== test/pdt_pin_model.sv
// far-side signal source for the timer pin
`timescale 1ns/1ns
module pdt_pin_model (
   input wire logic mclk_i,
   input wire logic gate_i,
   input wire logic [3:0] edges_i,
   input wire logic load_i,
   output logic level_o
);
   logic [3:0] left_reg = 4'h0;
   logic [1:0] ph_reg = 2'h0;
   initial level_o = 1'b0;
   // slow toggling, four clocks a phase, so edges are never merged
   always @(posedge mclk_i) begin
      if (load_i) begin
         left_reg <= edges_i;
         ph_reg <= 2'h0;
      end else if (left_reg != 4'h0) begin
         ph_reg <= ph_reg + 2'h1;
         if (ph_reg == 2'h3) begin
            level_o <= ~level_o;
            if (!level_o) left_reg <= left_reg - 4'h1;
         end
      end else begin
         level_o <= gate_i;
      end
   end
endmodule : pdt_pin_model

// ===== test/tb.sv
// self-checking bench for the prescaled down-counter timer
`timescale 1ns/1ns
module tb;
   logic mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, rd_seen = 0;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, irq_vector_o, d;
   logic timer_pin_o, timer_pin_oe_o, irq_o, lvl, pin, gate = 0, load = 0;
   logic [3:0] edges = 4'h0;
   logic [7:0] exp_q[$];
   int err_count = 0, samples_checked = 0, cyc = 0;
   always #50 mclk_i = ~mclk_i;
   assign pin = timer_pin_oe_o ? timer_pin_o : lvl;
   pdt_timer pdt_timer_i (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .timer_pin_i(pin), .rdata_o, .timer_pin_o, .timer_pin_oe_o, .irq_o,
      .irq_vector_o);
   pdt_pin_model pdt_pin_model_i (.mclk_i, .gate_i(gate), .edges_i(edges),
      .load_i(load), .level_o(lvl));
   task check(input logic [7:0] seen, input logic [7:0] want);
      samples_checked++;
      if (seen !== want) begin
         err_count++;
         $display("FAIL %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   task give_verdict;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge mclk_i) {addr_i, wdata_i, wr_i} = {a, v, 1'b1};
      @(negedge mclk_i) wr_i = 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] want);
      @(negedge mclk_i) {addr_i, rd_i} = {a, 1'b1};
      exp_q.push_back(want);
      @(negedge mclk_i) rd_i = 1'b0;
   endtask : rd
   task idle(input int n);
      repeat (n) @(negedge mclk_i);
   endtask : idle
   // read data stands one cycle, so it is taken at the next falling edge
   always @(posedge mclk_i) begin
      rd_seen <= rd_i;
      cyc <= cyc + 1;
   end
   always @(negedge mclk_i) if (rd_seen) check(rdata_o, exp_q.pop_front());
   always @(posedge mclk_i) if (cyc == 2000) begin
      err_count++;
      give_verdict;
   end
   initial begin
      d = 8'($urandom(94407));
      idle(8);
      rst_i = 1'b0;
      rd(8'hD2, 8'h7F);
      rd(8'hD3, 8'hFF);
      rd(8'hD4, 8'h00);
      rd(8'hD5, 8'h00);
      check(irq_vector_o, 8'h03);
      $display("reset test done");
      repeat (4) begin
         d = 8'($urandom);
         wr(8'hD3, d);
         rd(8'hD3, d);
      end
      wr(8'hD2, 8'h11);
      rd(8'hD2, 8'h7F);
      wr(8'hD4, 8'h00);
      wr(8'hD3, 8'h00);
      rd(8'hD4, 8'h80);
      wr(8'hD4, 8'h00);
      wr(8'hD4, 8'h80);
      rd(8'hD4, 8'h80);
      $display("register test done");
      wr(8'hD4, 8'h00);
      wr(8'hD3, 8'h02);
      wr(8'hD4, 8'h68);
      idle(30);
      check(8'(irq_o), 8'h01);
      rd(8'hD4, 8'hE8);
      wr(8'hD4, 8'h68);
      idle(2);
      check(8'(irq_o), 8'h00);
      wr(8'hD4, 8'h00);
      rd(8'hD2, 8'h7F);
      $display("internal count test done");
      wr(8'hD3, 8'h01);
      wr(8'hD4, 8'h28);
      idle(10);
      wr(8'hD3, 8'h05);
      rd(8'hD3, 8'h05);
      rd(8'hD4, 8'h28);
      wr(8'hD4, 8'h00);
      $display("write priority test done");
      wr(8'hD3, 8'h03);
      wr(8'hD4, 8'h08);
      @(negedge mclk_i) {edges, load} = {4'h3, 1'b1};
      @(negedge mclk_i) load = 1'b0;
      idle(40);
      rd(8'hD3, 8'h00);
      rd(8'hD2, 8'h7C);
      rd(8'hD4, 8'h88);
      $display("event test done");
      wr(8'hD4, 8'h00);
      wr(8'hD3, 8'h03);
      wr(8'hD4, 8'h09);
      @(negedge mclk_i) {edges, load} = {4'h4, 1'b1};
      @(negedge mclk_i) load = 1'b0;
      idle(50);
      rd(8'hD3, 8'h01);
      rd(8'hD2, 8'h7B);
      rd(8'hD4, 8'h09);
      $display("tap test done");
      wr(8'hD4, 8'h00);
      wr(8'hD4, 8'h18);
      idle(30);
      rd(8'hD2, 8'h7F);
      wr(8'hD4, 8'h00);
      gate = 1'b1;
      wr(8'hD4, 8'h18);
      idle(26);
      rd(8'hD2, 8'h7D);
      $display("gated test done");
      wr(8'hD4, 8'hB0);
      idle(2);
      check(8'({timer_pin_oe_o, timer_pin_o}), 8'h03);
      wr(8'hD4, 8'h20);
      idle(2);
      check(8'({timer_pin_oe_o, timer_pin_o}), 8'h03);
      wr(8'hD4, 8'hA0);
      idle(2);
      check(8'({timer_pin_oe_o, timer_pin_o}), 8'h02);
      $display("output test done");
      @(negedge mclk_i) rst_i = 1'b1;
      idle(2);
      rst_i = 1'b0;
      check(8'({timer_pin_oe_o, timer_pin_o}), 8'h00);
      rd(8'hD3, 8'hFF);
      rd(8'hD2, 8'h7F);
      rd(8'hD4, 8'h00);
      $display("mid-run reset test done");
      give_verdict;
   end
endmodule : tb
